// File: design/synth_cfg_pkg.sv
// constants of the synthesiser, calibration and modem configuration registers
//
// Contract
// - ext_loop_filter_sel picks external or internal filter
// - open loop: its 1-to-0 edge samples comparator
// - tuning_alarm_off 1 disables the tuning alarm
// - report tune_high_flag and tune_low_flag, status only
// - lock_pin_source routes signals to charge-pump pin
// - code 1000 drives tx_powered_ind, high when powered
// - coarse precision: lock 127, reset 111
// - fine precision: lock 31, reset 15
// - lock_now_flag and lock_steady_flag read-only status
// - rising calib_go starts calibration; low means inactive
// - calib_both_sets stores to A and B, else freq_set_sel
// - calib_wait_len 1 full wait, 0 half wait
// - wait scales with reference, 14 ms at 2 MHz
// - calib_drive_double doubles calibration current
// - calib_done_flag set on completion, resets to zero
// - crystal_range_sel declares crystal range, reset 00
// - freq_set_sel zero picks set A, one set B
// - tx_powerdown powers down interface and amplifier
package synth_cfg_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [6:0] SYNTH_LOOP_ADDR  = 7'h0C;
   localparam logic [6:0] LOCK_DETECT_ADDR = 7'h0D;
   localparam logic [6:0] CALIB_ADDR       = 7'h0E;
   localparam logic [6:0] MODEM_ADDR       = 7'h11;

   // ****************************************
   // field positions
   // ****************************************
   localparam int EXT_LOOP_FILTER_SEL_BIT = 7;
   localparam int REF_DIV_LSB    = 3;
   localparam int ALARM_OFF_BIT  = 2;
   localparam int TUNE_HIGH_BIT  = 1;
   localparam int TUNE_LOW_BIT   = 0;
   localparam int LOCK_SRC_LSB   = 4;
   localparam int LOCK_PREC_BIT  = 3;
   localparam int LOCK_WIN_BIT   = 2;
   localparam int LOCK_NOW_BIT   = 1;
   localparam int LOCK_STEADY_BIT = 0;
   localparam int CAL_GO_BIT     = 7;
   localparam int CAL_BOTH_BIT   = 6;
   localparam int CAL_WAIT_BIT   = 5;
   localparam int CAL_DRIVE_BIT  = 4;
   localparam int CAL_DONE_BIT   = 3;
   localparam int CAL_SEED_LSB   = 0;
   localparam int RATE_LSB       = 4;
   localparam int FORMAT_LSB     = 2;
   localparam int XTAL_LSB       = 0;

   // ****************************************
   // reset values and writable masks
   // ****************************************
   localparam logic [7:0] SYNTH_LOOP_RST  = 8'h10;
   localparam logic [7:0] LOCK_DETECT_RST = 8'h00;
   localparam logic [7:0] CALIB_RST       = 8'h05;
   localparam logic [7:0] MODEM_RST       = 8'h24;
   localparam logic [7:0] SYNTH_LOOP_WMASK  = 8'hFC;
   localparam logic [7:0] LOCK_DETECT_WMASK = 8'hFC;
   localparam logic [7:0] CALIB_WMASK       = 8'hF7;
   localparam logic [7:0] MODEM_WMASK       = 8'h7F;
   localparam logic [3:0] REF_DIV_MIN       = 4'h2;

   // ****************************************
   // lock detector thresholds
   // ****************************************
   localparam logic [6:0] LOCK_THR_COARSE  = 7'h7F;
   localparam logic [6:0] RESET_THR_COARSE = 7'h6F;
   localparam logic [6:0] LOCK_THR_FINE    = 7'h1F;
   localparam logic [6:0] RESET_THR_FINE   = 7'h0F;

   // ****************************************
   // pin source codes
   // ****************************************
   typedef enum logic [3:0] {
      PIN_NORMAL  = 4'h0,
      PIN_STEADY  = 4'h1,
      PIN_NOW     = 4'h2,
      PIN_HIGH    = 4'h3,
      PIN_LOW     = 4'h4,
      PIN_CALDONE = 4'h5,
      PIN_REF_CLK_DIVISOR  = 4'h7,
      PIN_TXIND   = 4'h8,
      PIN_COMPARE = 4'hF
   } pin_src_t;

   // ****************************************
   // calibration timing, counted in reference ticks
   // ****************************************
   localparam int CAL_WAIT_MS      = 14;
   localparam int CAL_REF_KHZ      = 2000;
   localparam int CAL_WAIT_REF_CYC = CAL_WAIT_MS * CAL_REF_KHZ;

   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_WAIT = 3'b010,
      CAL_DONE = 3'b100
   } cal_state_t;
endpackage

// File: design/ref_clk_divider.sv
// reference divider producing the reference tick and divided output
`timescale 1ns/1ns
`default_nettype none
module ref_clk_divider (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] divisor,
   output logic            refTick,
   output logic            refDivOut
);
   logic [3:0] count_ff;
   logic [3:0] effDiv;

   // illegal codes 0 and 1 run as divide by 2 rather than stall
   assign effDiv  = (divisor < synth_cfg_pkg::REF_DIV_MIN) ? synth_cfg_pkg::REF_DIV_MIN
                                                          : divisor;
   assign refTick = (count_ff >= effDiv - 4'h1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count_ff <= 4'h0;
      end else if (refTick) begin
         count_ff <= 4'h0;
      end else begin
         count_ff <= count_ff + 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         refDivOut <= 1'b0;
      end else if (refTick) begin
         refDivOut <= ~refDivOut;
      end
   end
endmodule // ref_clk_divider
`default_nettype wire

// File: design/calib_sequencer.sv
// self-calibration sequencer timed by reference ticks
`timescale 1ns/1ns
`default_nettype none
module calib_sequencer #(
   parameter int WAIT_REF_CYC = synth_cfg_pkg::CAL_WAIT_REF_CYC
) (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic refTick,
   input  wire logic calibGo,
   input  wire logic waitFull,
   output logic      calibBusy,
   output logic      calibDone,
   output logic      calibFinish
);
   synth_cfg_pkg::cal_state_t state_ff;
   logic        goLast_ff;
   logic [15:0] waitCnt_ff;
   logic [15:0] waitTarget;
   logic        goRise;

   assign waitTarget = waitFull ? 16'(WAIT_REF_CYC) : 16'(WAIT_REF_CYC / 2);
   assign goRise      = calibGo && !goLast_ff;
   assign calibBusy   = (state_ff == synth_cfg_pkg::CAL_WAIT);
   assign calibFinish = calibBusy && calibGo && refTick && (waitCnt_ff >= waitTarget - 16'h1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         goLast_ff <= 1'b0;
      end else begin
         goLast_ff <= calibGo;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff   <= synth_cfg_pkg::CAL_IDLE;
         waitCnt_ff <= 16'h0;
      end else begin
         case (state_ff)
            synth_cfg_pkg::CAL_IDLE, synth_cfg_pkg::CAL_DONE: begin
               if (goRise) begin
                  state_ff   <= synth_cfg_pkg::CAL_WAIT;
                  waitCnt_ff <= 16'h0;
               end
            end
            synth_cfg_pkg::CAL_WAIT: begin
               if (!calibGo) begin
                  state_ff <= synth_cfg_pkg::CAL_IDLE;
               end else if (calibFinish) begin
                  state_ff <= synth_cfg_pkg::CAL_DONE;
               end else if (refTick) begin
                  waitCnt_ff <= waitCnt_ff + 16'h1;
               end
            end
            default: state_ff <= synth_cfg_pkg::CAL_IDLE;
         endcase
      end
   end

   assign calibDone = (state_ff == synth_cfg_pkg::CAL_DONE);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_start; goRise && !calibBusy; endsequence
   sequence s_finish; calibFinish; endsequence
   a_cal_start_busy: assert property (s_start |=> calibBusy)
      else $error("calibration did not start on rising go");
   a_cal_done_set: assert property (s_finish |=> calibDone && !calibBusy)
      else $error("done flag not set after calibration end");
   a_cal_abort: assert property (calibBusy && !calibGo |=> !calibBusy && !calibDone)
      else $error("calibration still active with go low");
endmodule // calib_sequencer
`default_nettype wire

// File: design/synth_calib_modem_config.sv
// synthesiser, lock detector, calibration and modem configuration registers
`timescale 1ns/1ns
`default_nettype none
module synth_calib_modem_config #(
   parameter int CAL_WAIT_REF_CYC = synth_cfg_pkg::CAL_WAIT_REF_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [6:0] cfgAddr,
   input  wire logic [7:0] cfgWrData,
   input  wire logic       cfgWrEn,
   input  wire logic       cfgRdEn,
   output logic      [7:0] cfgRdData,
   input  wire logic       freqSetSel,
   input  wire logic       txPowerdown,
   input  wire logic       openLoopTest,
   input  wire logic       freqCompareOut,
   input  wire logic       tuneHighRaw,
   input  wire logic       tuneLowRaw,
   input  wire logic       phaseCmpValid,
   input  wire logic       phaseCmpGood,
   input  wire logic       chargePumpIn,
   output logic            chargePumpPin,
   output logic            extLoopFilterSel,
   output logic            compareSample,
   output logic            tuningAlarmEn,
   output logic            calibDriveDouble,
   output logic      [2:0] calibSeed,
   output logic            calibBusy,
   output logic            calibStoreA,
   output logic            calibStoreB,
   output logic      [2:0] symbolRateSel,
   output logic      [1:0] lineFormatSel,
   output logic      [1:0] crystalRangeSel,
   output logic            txPoweredInd,
   output logic            refTick
);
   // ****************************************
   // register storage
   // ****************************************
   logic [7:0] synthLoop_ff;
   logic [7:0] lockDetect_ff;
   logic [7:0] calib_ff;
   logic [7:0] modem_ff;
   logic       wrSynth;
   logic       wrLock;
   logic       wrCalib;
   logic       wrModem;

   assign wrSynth = cfgWrEn && (cfgAddr == synth_cfg_pkg::SYNTH_LOOP_ADDR);
   assign wrLock  = cfgWrEn && (cfgAddr == synth_cfg_pkg::LOCK_DETECT_ADDR);
   assign wrCalib = cfgWrEn && (cfgAddr == synth_cfg_pkg::CALIB_ADDR);
   assign wrModem = cfgWrEn && (cfgAddr == synth_cfg_pkg::MODEM_ADDR);

   // status bit positions are masked off, so writes never touch them
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         synthLoop_ff <= synth_cfg_pkg::SYNTH_LOOP_RST;
      end else if (wrSynth) begin
         synthLoop_ff <= cfgWrData & synth_cfg_pkg::SYNTH_LOOP_WMASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lockDetect_ff <= synth_cfg_pkg::LOCK_DETECT_RST;
      end else if (wrLock) begin
         lockDetect_ff <= cfgWrData & synth_cfg_pkg::LOCK_DETECT_WMASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         calib_ff <= synth_cfg_pkg::CALIB_RST;
      end else if (wrCalib) begin
         calib_ff <= cfgWrData & synth_cfg_pkg::CALIB_WMASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         modem_ff <= synth_cfg_pkg::MODEM_RST;
      end else if (wrModem) begin
         modem_ff <= cfgWrData & synth_cfg_pkg::MODEM_WMASK;
      end
   end

   // ****************************************
   // field decode
   // ****************************************
   logic [3:0] refClkDivisor;
   logic [3:0] lockPinSource;
   logic       lockPrecisionSel;
   logic       calibGo;
   logic       calibBothSets;
   logic       calibWaitLen;

   assign extLoopFilterSel = synthLoop_ff[synth_cfg_pkg::EXT_LOOP_FILTER_SEL_BIT];
   assign refClkDivisor    = synthLoop_ff[synth_cfg_pkg::REF_DIV_LSB +: 4];
   assign tuningAlarmEn    = !synthLoop_ff[synth_cfg_pkg::ALARM_OFF_BIT];
   assign lockPinSource    = lockDetect_ff[synth_cfg_pkg::LOCK_SRC_LSB +: 4];
   assign lockPrecisionSel = lockDetect_ff[synth_cfg_pkg::LOCK_PREC_BIT];
   assign calibGo          = calib_ff[synth_cfg_pkg::CAL_GO_BIT];
   assign calibBothSets    = calib_ff[synth_cfg_pkg::CAL_BOTH_BIT];
   assign calibWaitLen     = calib_ff[synth_cfg_pkg::CAL_WAIT_BIT];
   assign calibDriveDouble = calib_ff[synth_cfg_pkg::CAL_DRIVE_BIT];
   assign calibSeed        = calib_ff[synth_cfg_pkg::CAL_SEED_LSB +: 3];
   assign symbolRateSel    = modem_ff[synth_cfg_pkg::RATE_LSB +: 3];
   assign lineFormatSel    = modem_ff[synth_cfg_pkg::FORMAT_LSB +: 2];
   assign crystalRangeSel  = modem_ff[synth_cfg_pkg::XTAL_LSB +: 2];
   assign txPoweredInd     = !txPowerdown;

   // ****************************************
   // open-loop comparator sample
   // ****************************************
   logic extFilterLast_ff;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         extFilterLast_ff <= 1'b0;
      end else begin
         extFilterLast_ff <= extLoopFilterSel;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         compareSample <= 1'b0;
      end else if (openLoopTest && extFilterLast_ff && !extLoopFilterSel) begin
         compareSample <= freqCompareOut;
      end
   end

   // ****************************************
   // tuning alarms and lock detector
   // ****************************************
   logic       tuneHighFlag;
   logic       tuneLowFlag;
   logic [6:0] lockCount_ff;
   logic [6:0] lockThr;
   logic [6:0] resetThr;
   logic       lockNow_ff;
   logic       lockSteady_ff;

   assign tuneHighFlag = tuneHighRaw && tuningAlarmEn;
   assign tuneLowFlag  = tuneLowRaw && tuningAlarmEn;
   assign lockThr  = lockPrecisionSel ? synth_cfg_pkg::LOCK_THR_FINE
                                      : synth_cfg_pkg::LOCK_THR_COARSE;
   assign resetThr = lockPrecisionSel ? synth_cfg_pkg::RESET_THR_FINE
                                      : synth_cfg_pkg::RESET_THR_COARSE;

   // up on a good compare, down on a bad one; the gap gives hysteresis
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lockCount_ff <= 7'h00;
      end else if (phaseCmpValid && phaseCmpGood) begin
         if (lockCount_ff < lockThr) begin
            lockCount_ff <= lockCount_ff + 7'h01;
         end
      end else if (phaseCmpValid && lockCount_ff != 7'h00) begin
         lockCount_ff <= lockCount_ff - 7'h01;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lockNow_ff <= 1'b0;
      end else if (phaseCmpValid) begin
         lockNow_ff <= phaseCmpGood;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lockSteady_ff <= 1'b0;
      end else if (lockCount_ff >= lockThr) begin
         lockSteady_ff <= 1'b1;
      end else if (lockCount_ff < resetThr) begin
         lockSteady_ff <= 1'b0;
      end
   end

   // ****************************************
   // reference divider and calibration
   // ****************************************
   logic refDivOut;
   logic calibDone;
   logic calibFinish;

   ref_clk_divider uDiv (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .divisor   (refClkDivisor),
      .refTick   (refTick),
      .refDivOut (refDivOut)
   );

   calib_sequencer #(.WAIT_REF_CYC(CAL_WAIT_REF_CYC)) uCal (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .refTick     (refTick),
      .calibGo     (calibGo),
      .waitFull    (calibWaitLen),
      .calibBusy   (calibBusy),
      .calibDone   (calibDone),
      .calibFinish (calibFinish)
   );

   assign calibStoreA = calibFinish && (calibBothSets || !freqSetSel);
   assign calibStoreB = calibFinish && (calibBothSets || freqSetSel);

   // ****************************************
   // charge-pump pin source
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         chargePumpPin <= 1'b0;
      end else begin
         case (synth_cfg_pkg::pin_src_t'(lockPinSource))
            synth_cfg_pkg::PIN_NORMAL:  chargePumpPin <= chargePumpIn;
            synth_cfg_pkg::PIN_STEADY:  chargePumpPin <= lockSteady_ff;
            synth_cfg_pkg::PIN_NOW:     chargePumpPin <= lockNow_ff;
            synth_cfg_pkg::PIN_HIGH:    chargePumpPin <= tuneHighFlag;
            synth_cfg_pkg::PIN_LOW:     chargePumpPin <= tuneLowFlag;
            synth_cfg_pkg::PIN_CALDONE: chargePumpPin <= calibDone;
            synth_cfg_pkg::PIN_REF_CLK_DIVISOR:  chargePumpPin <= refDivOut;
            synth_cfg_pkg::PIN_TXIND:   chargePumpPin <= txPoweredInd;
            synth_cfg_pkg::PIN_COMPARE: chargePumpPin <= freqCompareOut;
            default:                    chargePumpPin <= 1'b0;
         endcase
      end
   end

   // ****************************************
   // read port, status bits merged live
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfgRdData <= 8'h00;
      end else if (cfgRdEn) begin
         case (cfgAddr)
            synth_cfg_pkg::SYNTH_LOOP_ADDR:
               cfgRdData <= {synthLoop_ff[7:2], tuneHighFlag, tuneLowFlag};
            synth_cfg_pkg::LOCK_DETECT_ADDR:
               cfgRdData <= {lockDetect_ff[7:2], lockNow_ff, lockSteady_ff};
            synth_cfg_pkg::CALIB_ADDR:
               cfgRdData <= {calib_ff[7:4], calibDone, calib_ff[2:0]};
            synth_cfg_pkg::MODEM_ADDR: cfgRdData <= modem_ff;
            default:                   cfgRdData <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_filter_write: assert property (wrSynth |=> extLoopFilterSel == $past(cfgWrData[7]))
      else $error("filter select not taken from write");
   a_compare_sample: assert property (openLoopTest && $fell(extLoopFilterSel)
      |=> compareSample == $past(freqCompareOut))
      else $error("comparator not sampled on filter fall");
   a_alarm_gated: assert property (!tuningAlarmEn |-> !tuneHighFlag && !tuneLowFlag)
      else $error("alarm flag shown while alarm off");
   a_pin_steady: assert property (lockPinSource == 4'h1 |=> chargePumpPin == $past(lockSteady_ff))
      else $error("pin does not follow steady lock");
   a_pin_txind: assert property (lockPinSource == 4'h8 && !txPowerdown |=> chargePumpPin)
      else $error("pin low while transmitter powered");
   a_lock_coarse: assert property (!lockPrecisionSel && lockCount_ff == 7'h7F |=> lockSteady_ff)
      else $error("no lock at coarse threshold");
   a_lock_fine: assert property (lockPrecisionSel && lockCount_ff == 7'h1F |=> lockSteady_ff)
      else $error("no lock at fine threshold");
   a_unlock_coarse: assert property (!lockPrecisionSel && lockCount_ff == 7'h6E
      && $stable(lockPrecisionSel) |=> !lockSteady_ff)
      else $error("lock kept below coarse reset threshold");
   a_status_ro: assert property (wrLock && !phaseCmpValid |=> $stable(lockNow_ff))
      else $error("status flag changed by write");
   a_store_sets: assert property (calibFinish && calibBothSets |-> calibStoreA && calibStoreB)
      else $error("dual store missed a set");
   a_modem_read: assert property (cfgRdEn && cfgAddr == 7'h11 && !cfgWrEn
      |=> cfgRdData == {1'b0, symbolRateSel, lineFormatSel, crystalRangeSel})
      else $error("modem read wrong");
   a_unlock_fine: assert property (lockPrecisionSel && lockCount_ff == 7'h0E
      |=> !lockSteady_ff)
      else $error("lock kept below fine reset threshold");
   a_lock_now: assert property (phaseCmpValid |=> lockNow_ff == $past(phaseCmpGood))
      else $error("instant lock flag not taken from compare");
   a_pin_caldone: assert property (lockPinSource == 4'h5
      |=> chargePumpPin == $past(calibDone))
      else $error("pin does not follow calibration done");
   a_pin_unused: assert property (lockPinSource == 4'h6 |=> !chargePumpPin)
      else $error("unused pin code drives high");
   a_pin_compare: assert property (lockPinSource == 4'hF
      |=> chargePumpPin == $past(freqCompareOut))
      else $error("pin does not follow comparator");
   a_store_single: assert property (calibFinish && !calibBothSets
      |-> calibStoreB == freqSetSel && calibStoreA == !freqSetSel)
      else $error("single store went to wrong set");
   a_store_idle: assert property (!calibFinish |-> !calibStoreA && !calibStoreB)
      else $error("store pulse outside calibration end");
   a_flag_read: assert property (cfgRdEn && cfgAddr == 7'h0C
      |=> cfgRdData[1:0] == $past({tuneHighFlag, tuneLowFlag}))
      else $error("tuning flags not read live");
   a_drive_write: assert property (wrCalib
      |=> calibDriveDouble == $past(cfgWrData[4]))
      else $error("current doubling not taken from write");
endmodule // synth_calib_modem_config
`default_nettype wire

// File: verif/mcu_model.sv
// controller model driving the configuration port
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
   input  wire logic       sys_clk,
   output logic      [6:0] cfgAddr,
   output logic      [7:0] cfgWrData,
   output logic            cfgWrEn,
   output logic            cfgRdEn,
   input  wire logic [7:0] cfgRdData
);
   // ****************************************
   // settings the controller must keep
   // ****************************************
   localparam logic [2:0] SEED_NORMAL = 3'h6;
   localparam logic [7:0] WIN_CLEAR   = 8'hFB;
   initial begin
      cfgAddr = 7'h7F;
      cfgWrData = 8'h00;
      cfgWrEn = 1'b0;
      cfgRdEn = 1'b0;
   end
   // released lines show the inverse so stale values never look valid
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (a == synth_cfg_pkg::LOCK_DETECT_ADDR) v = v & WIN_CLEAR;
      if (a == synth_cfg_pkg::CALIB_ADDR) v[2:0] = SEED_NORMAL;
      @(posedge sys_clk);
      cfgAddr <= a;
      cfgWrData <= v;
      cfgWrEn <= 1'b1;
      @(posedge sys_clk);
      cfgWrEn <= 1'b0;
      cfgAddr <= ~a;
      cfgWrData <= ~v;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      cfgAddr <= a;
      cfgRdEn <= 1'b1;
      @(posedge sys_clk);
      cfgRdEn <= 1'b0;
      cfgAddr <= ~a;
      #1 d = cfgRdData;
   endtask
endmodule // mcu_model
`default_nettype wire

// File: verif/synth_calib_modem_config_tb.sv
// self-checking bench for the configuration register group
`timescale 1ns/1ns
`default_nettype none
module synth_calib_modem_config_tb;
   logic       sys_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [6:0] cfgAddr;
   logic [7:0] cfgWrData, cfgRdData;
   logic       cfgWrEn, cfgRdEn, chargePumpPin, extLoopFilterSel, compareSample, tuningAlarmEn;
   logic       calibDriveDouble, calibBusy, calibStoreA, calibStoreB, txPoweredInd, refTick;
   logic       freqSetSel = 0, txPowerdown = 1, openLoopTest = 0, freqCompareOut = 0;
   logic       tuneHighRaw = 0, tuneLowRaw = 0, phaseCmpValid = 0, phaseCmpGood = 0;
   logic       chargePumpIn = 0;
   logic [2:0] calibSeed, symbolRateSel;
   logic [1:0] lineFormatSel, crystalRangeSel;
   int         fails = 0, checksDone = 0, nFull, nHalf, nTick;
   logic [6:0] addrs [5] = '{7'h0C, 7'h0D, 7'h0E, 7'h11, 7'h12};
   logic [7:0] rstv [5] = '{8'h10, 8'h00, 8'h05, 8'h24, 8'h00};
   logic [7:0] expv [5] = '{8'hFC, 8'hF8, 8'hF6, 8'h7F, 8'h00};
   logic [15:0] pinMap = 16'h8111;
   // short wait keeps calibration runs brief
   synth_calib_modem_config #(.CAL_WAIT_REF_CYC(8)) u_dut (.sys_clk, .rst_b, .cfgAddr,
      .cfgWrData, .cfgWrEn, .cfgRdEn, .cfgRdData, .freqSetSel, .txPowerdown, .openLoopTest,
      .freqCompareOut, .tuneHighRaw, .tuneLowRaw, .phaseCmpValid, .phaseCmpGood, .chargePumpIn,
      .chargePumpPin, .extLoopFilterSel, .compareSample, .tuningAlarmEn, .calibDriveDouble,
      .calibSeed, .calibBusy, .calibStoreA, .calibStoreB, .symbolRateSel, .lineFormatSel,
      .crystalRangeSel, .txPoweredInd, .refTick);
   mcu_model u_mcu (.sys_clk, .cfgAddr, .cfgWrData, .cfgWrEn, .cfgRdEn, .cfgRdData);
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   // ****************************************
   // compare and access tasks
   // ****************************************
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rdChk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_mcu.rd(a, d);
      chk($sformatf("register %h", a), d, exp);
   endtask
   task automatic lockStep(input int n, input logic good, input logic [7:0] exp);
      repeat (n) begin
         @(posedge sys_clk);
         phaseCmpValid <= 1'b1;
         phaseCmpGood <= good;
      end
      @(posedge sys_clk);
      phaseCmpValid <= 1'b0;
      rdChk(7'h0D, exp);
   endtask
   task automatic waitStore(output int n);
      n = 0;
      while (calibStoreA !== 1'b1 && calibStoreB !== 1'b1) begin
         @(posedge sys_clk);
         #1 n++;
         if (n > 200) begin
            fails++;
            final_report();
         end
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 5; i++) rdChk(addrs[i], rstv[i]);
      for (int i = 0; i < 5; i++) u_mcu.wr(addrs[i], 8'hFF);
      for (int i = 0; i < 5; i++) rdChk(addrs[i], expv[i]);
      chk("fields", {extLoopFilterSel, tuningAlarmEn, calibDriveDouble, 2'h0, calibSeed},
          8'hA6);
      chk("modem", {1'b0, symbolRateSel, lineFormatSel, crystalRangeSel}, 8'h7F);
      // the all-ones write started a calibration; stop it so the done flag stays low
      u_mcu.wr(7'h0E, 8'h00);
      $display("test registers done");
      u_mcu.wr(7'h0C, 8'h10);
      repeat (2) @(posedge sys_clk);
      #1 chk("closed loop sample", compareSample, 8'h00);
      chk("abort busy", calibBusy, 8'h00);
      openLoopTest <= 1'b1;
      freqCompareOut <= 1'b1;
      tuneHighRaw <= 1'b1;
      u_mcu.wr(7'h0C, 8'h90);
      u_mcu.wr(7'h0C, 8'h10);
      rdChk(7'h0C, 8'h12);
      chk("open loop sample", compareSample, 8'h01);
      tuneHighRaw <= 1'b0;
      tuneLowRaw <= 1'b1;
      chargePumpIn <= 1'b1;
      txPowerdown <= 1'b0;
      rdChk(7'h0C, 8'h11);
      for (int i = 0; i < 16; i++) begin
         if (i != 7) begin
            u_mcu.wr(7'h0D, 8'(i << 4));
            repeat (2) @(posedge sys_clk);
            #1 chk($sformatf("pin code %0d", i), chargePumpPin, pinMap[i]);
         end
      end
      chk("powered", txPoweredInd, 8'h01);
      $display("test pin done");
      u_mcu.wr(7'h0D, 8'h10);
      lockStep(126, 1'b1, 8'h12);
      lockStep(1, 1'b1, 8'h13);
      lockStep(16, 1'b0, 8'h11);
      lockStep(1, 1'b0, 8'h10);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      nTick = 0;
      repeat (20) begin
         @(posedge sys_clk);
         #1 nTick += int'(refTick);
      end
      chk("ref ticks", 8'(nTick), 8'h0A);
      u_mcu.wr(7'h0D, 8'h18);
      lockStep(30, 1'b1, 8'h1A);
      lockStep(1, 1'b1, 8'h1B);
      chk("steady pin", chargePumpPin, 8'h01);
      lockStep(17, 1'b0, 8'h18);
      $display("test lock done");
      u_mcu.wr(7'h0E, 8'hE0);
      waitStore(nFull);
      chk("store both", {calibStoreA, calibStoreB}, 8'h03);
      rdChk(7'h0E, 8'hEE);
      chk("busy after end", calibBusy, 8'h00);
      u_mcu.wr(7'h0E, 8'h00);
      freqSetSel <= 1'b1;
      u_mcu.wr(7'h0E, 8'h80);
      waitStore(nHalf);
      chk("store set", {calibStoreA, calibStoreB}, 8'h01);
      chk("half wait", 8'(nFull - nHalf >= 6 && nFull - nHalf <= 10), 8'h01);
      $display("test calibration done");
      final_report();
   end
endmodule // synth_calib_modem_config_tb
`default_nettype wire
